// ==== vcr_pkg.sv ====
// Constants shared by the vertical timing and cursor controller.
package vcr_pkg;
  // Register indices reached through the indexed data port.
  localparam logic [7:0] VCR_IDX_TIMING_OVERFLOW = 8'h07;
  localparam logic [7:0] VCR_IDX_CHARACTER_HEIGHT = 8'h09;
  localparam logic [7:0] VCR_IDX_CURSOR_FIRST_LINE = 8'h0A;
  localparam logic [7:0] VCR_IDX_CURSOR_LAST_LINE_SKEW = 8'h0B;
  localparam logic [7:0] VCR_IDX_DISPLAY_START_HIGH = 8'h0C;
  localparam logic [7:0] VCR_IDX_DISPLAY_START_LOW = 8'h0D;
  localparam logic [7:0] VCR_IDX_CURSOR_POSITION_HIGH = 8'h0E;
  localparam logic [7:0] VCR_IDX_CURSOR_POSITION_LOW = 8'h0F;
  localparam logic [7:0] VCR_IDX_VSYNC_BEGIN_LOW = 8'h10;
  localparam logic [7:0] VCR_IDX_VSYNC_FINISH_PROTECT = 8'h11;
  localparam logic [7:0] VCR_IDX_ACTIVE_LAST_LINE_LOW = 8'h12;
  localparam logic [7:0] VCR_IDX_ROW_PITCH = 8'h13;
  // Highest index covered by write protection.
  localparam logic [7:0] VCR_IDX_PROTECT_LAST = 8'h07;

  // Field positions.
  localparam int VCR_OVF_VS_BIT9 = 7;
  localparam int VCR_OVF_DE_BIT9 = 6;
  localparam int VCR_OVF_ALWAYS_WR = 4;
  localparam int VCR_OVF_VS_BIT8 = 2;
  localparam int VCR_OVF_DE_BIT8 = 1;
  localparam int VCR_CUR_OFF_BIT = 5;
  localparam int VCR_PROTECT_BIT = 7;
  localparam int VCR_VINT_ENABLE_BIT = 5;
  localparam int VCR_VINT_CLEAR_BIT = 4;

  // Masks that keep reserved bits reading as zero.
  localparam logic [7:0] VCR_MASK_FIRST_LINE = 8'h3F;
  localparam logic [7:0] VCR_MASK_LAST_LINE_SKEW = 8'h7F;
  localparam logic [7:0] VCR_MASK_FINISH_PROTECT = 8'hBF;
  localparam logic [7:0] VCR_MASK_CHAR_HEIGHT = 8'h1F;

  // Reset value of every stored register; protection is off after reset.
  localparam logic [7:0] VCR_REG_RESET = 8'h00;

  // Number of character clocks the cursor can be held back.
  localparam int VCR_SKEW_MAX = 3;
endpackage

// ==== vcr_crtc.sv ====
// Vertical timing, row addressing and text cursor of the display controller.
`timescale 1ns/1ps

// Contract
// R1 - Character height field holds lines per text row minus one; row scan wraps there.
// R2 - Cursor-off bit hides cursor; whole first-line register ignored in graphics modes.
// R3 - Cursor starts on the first-line row, counting from zero at box top.
// R4 - Cursor ends after the last-line row, same top-zero numbering.
// R5 - Skew code 0 to 3 delays cursor start and end by that many clocks.
// R6 - Display start is a 16-bit high/low pair; fetching begins there each frame.
// R7 - Cursor location is a 16-bit high/low pair naming the cursor character.
// R8 - Vsync begins on 10-bit line: low byte plus overflow bits 7 and 2.
// R9 - Vsync ends when low four line bits equal the 4-bit end field.
// R10 - Protect bit blocks writes to indices 00 to 07, except overflow bit 4.
// R11 - Vertical interrupt enable bit is stored and readable but steers nothing.
// R12 - Vertical interrupt clear bit is stored only; no interrupt exists.
// R13 - Last active line is 10-bit: low byte plus overflow bits 6 and 1.
// R14 - First active line is line 0; all vertical comparisons use this count.
// R15 - Row address advances by the 8-bit pitch in words or doublewords.
// R16 - Reserved bits of the two cursor shape registers read as zero.
// R17 - Cursor only at matching address, within line range, enabled, in text mode.
// R18 - Host writes the index port, then reads or writes the data port.
module vcr_crtc #(
  parameter int HCNT_W = 8,
  parameter int H_TOTAL = 100,
  parameter int H_ACTIVE = 80,
  parameter logic [9:0] V_TOTAL = 10'h1C1
) (
  input wire logic mclk, // Character clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic index_wr, // Strobe: load the index port from host_wdata.
  input wire logic data_wr, // Strobe: write host_wdata to the indexed register.
  input wire logic data_rd, // Strobe: read the indexed register.
  input wire logic [7:0] host_wdata, // Write data for index or data port.
  output logic [7:0] host_rdata, // Read data, valid the cycle after data_rd.
  input wire logic graphics_mode, // High while a graphics mode is active.
  input wire logic dword_pitch, // Clocking-mode selection: pitch counted in doublewords.
  output logic [15:0] fb_addr, // Frame buffer offset of the current character.
  output logic display_en, // High while the character is in the active area.
  output logic vsync, // Vertical sync pulse, active high.
  output logic cursor_on // Text cursor pixel row active, after skew.
);
  import vcr_pkg::*;

  typedef struct packed {
    logic [7:0] index;
    logic [7:0] overflow;
    logic [4:0] char_height;
    logic [7:0] cur_first;
    logic [7:0] cur_last_skew;
    logic [15:0] start;
    logic [15:0] cur_loc;
    logic [7:0] vs_begin;
    logic [7:0] vs_finish;
    logic [7:0] act_last;
    logic [7:0] pitch;
    logic [7:0] rdata;
    logic [HCNT_W-1:0] hcnt;
    logic [9:0] line;
    logic [4:0] rscan;
    logic [15:0] row_base;
    logic [15:0] addr;
    logic [VCR_SKEW_MAX-1:0] cur_pipe;
    logic cursor;
    logic vsync;
    logic disp_en;
  } vcr_state_s;

  localparam logic [HCNT_W-1:0] HCNT_LAST = HCNT_W'(H_TOTAL - 1);
  localparam logic [HCNT_W-1:0] HCNT_ACTIVE = HCNT_W'(H_ACTIVE);
  localparam logic [9:0] LINE_LAST = V_TOTAL - 10'h001;

  vcr_state_s s_q;
  vcr_state_s s_d;

  logic protect;
  logic [9:0] vs_start;
  logic [9:0] de_end;
  logic [9:0] next_line;
  logic [15:0] pitch_step;
  logic [15:0] char_addr;
  logic active;
  logic cur_raw;
  logic [1:0] skew;

  always_comb begin
    s_d = s_q;
    protect = s_q.vs_finish[VCR_PROTECT_BIT];
    vs_start = {s_q.overflow[VCR_OVF_VS_BIT9], s_q.overflow[VCR_OVF_VS_BIT8],
                s_q.vs_begin}; // [R8]
    de_end = {s_q.overflow[VCR_OVF_DE_BIT9], s_q.overflow[VCR_OVF_DE_BIT8],
              s_q.act_last}; // [R13]
    // Pitch is stored in word or doubleword units; the counter works in bytes.
    pitch_step = dword_pitch ? {6'h00, s_q.pitch, 2'h0} : {7'h00, s_q.pitch, 1'h0}; // [R15]
    skew = s_q.cur_last_skew[6:5];
    next_line = (s_q.line == LINE_LAST) ? 10'h000 : s_q.line + 10'h001;

    // Host side: index load, register write and registered read.
    if (index_wr) begin // [R18]
      s_d.index = host_wdata;
    end
    if (data_wr) begin
      // Writes at or below the protected index are held off while protect is set.
      if (protect && s_q.index <= VCR_IDX_PROTECT_LAST) begin // [R10]
        if (s_q.index == VCR_IDX_TIMING_OVERFLOW) begin
          s_d.overflow[VCR_OVF_ALWAYS_WR] = host_wdata[VCR_OVF_ALWAYS_WR]; // [R10]
        end
      end else begin
        unique case (s_q.index)
          VCR_IDX_TIMING_OVERFLOW: s_d.overflow = host_wdata;
          VCR_IDX_CHARACTER_HEIGHT: s_d.char_height = host_wdata[4:0]; // [R1]
          VCR_IDX_CURSOR_FIRST_LINE: s_d.cur_first = host_wdata & VCR_MASK_FIRST_LINE; // [R16]
          VCR_IDX_CURSOR_LAST_LINE_SKEW: begin
            s_d.cur_last_skew = host_wdata & VCR_MASK_LAST_LINE_SKEW; // [R16]
          end
          VCR_IDX_DISPLAY_START_HIGH: s_d.start[15:8] = host_wdata; // [R6]
          VCR_IDX_DISPLAY_START_LOW: s_d.start[7:0] = host_wdata; // [R6]
          VCR_IDX_CURSOR_POSITION_HIGH: s_d.cur_loc[15:8] = host_wdata; // [R7]
          VCR_IDX_CURSOR_POSITION_LOW: s_d.cur_loc[7:0] = host_wdata; // [R7]
          VCR_IDX_VSYNC_BEGIN_LOW: s_d.vs_begin = host_wdata;
          // Interrupt enable and clear bits are kept for readback only.
          VCR_IDX_VSYNC_FINISH_PROTECT: begin
            s_d.vs_finish = host_wdata & VCR_MASK_FINISH_PROTECT; // [R11] [R12]
          end
          VCR_IDX_ACTIVE_LAST_LINE_LOW: s_d.act_last = host_wdata;
          VCR_IDX_ROW_PITCH: s_d.pitch = host_wdata;
          default: begin
          end
        endcase
      end
    end
    if (data_rd) begin
      unique case (s_q.index)
        VCR_IDX_TIMING_OVERFLOW: s_d.rdata = s_q.overflow;
        VCR_IDX_CHARACTER_HEIGHT: s_d.rdata = {3'h0, s_q.char_height};
        VCR_IDX_CURSOR_FIRST_LINE: s_d.rdata = s_q.cur_first; // [R16]
        VCR_IDX_CURSOR_LAST_LINE_SKEW: s_d.rdata = s_q.cur_last_skew; // [R16]
        VCR_IDX_DISPLAY_START_HIGH: s_d.rdata = s_q.start[15:8];
        VCR_IDX_DISPLAY_START_LOW: s_d.rdata = s_q.start[7:0];
        VCR_IDX_CURSOR_POSITION_HIGH: s_d.rdata = s_q.cur_loc[15:8];
        VCR_IDX_CURSOR_POSITION_LOW: s_d.rdata = s_q.cur_loc[7:0];
        VCR_IDX_VSYNC_BEGIN_LOW: s_d.rdata = s_q.vs_begin;
        VCR_IDX_VSYNC_FINISH_PROTECT: s_d.rdata = s_q.vs_finish; // [R11]
        VCR_IDX_ACTIVE_LAST_LINE_LOW: s_d.rdata = s_q.act_last;
        VCR_IDX_ROW_PITCH: s_d.rdata = s_q.pitch;
        default: s_d.rdata = VCR_REG_RESET;
      endcase
    end

    // Display side: character position within the current line.
    active = (s_q.line <= de_end) && (s_q.hcnt < HCNT_ACTIVE); // [R14]
    char_addr = s_q.row_base + {{(16 - HCNT_W){1'b0}}, s_q.hcnt}; // [R6]
    s_d.addr = char_addr;
    s_d.disp_en = active;

    cur_raw = active && !graphics_mode // [R2]
      && !s_q.cur_first[VCR_CUR_OFF_BIT] // [R2]
      && (char_addr == s_q.cur_loc) // [R7] [R17]
      && (s_q.rscan >= s_q.cur_first[4:0]) // [R3]
      && (s_q.rscan <= s_q.cur_last_skew[4:0]); // [R4] [R17]
    // A short shift line gives the skew taps; the output flop adds one clock to every code, as the address flop does.
    s_d.cur_pipe = {s_q.cur_pipe[VCR_SKEW_MAX-2:0], cur_raw}; // [R5]
    unique case (skew)
      2'h0: s_d.cursor = cur_raw; // [R5]
      2'h1: s_d.cursor = s_q.cur_pipe[0];
      2'h2: s_d.cursor = s_q.cur_pipe[1];
      2'h3: s_d.cursor = s_q.cur_pipe[2];
    endcase

    // Line end: advance vertical counters and sync.
    if (s_q.hcnt == HCNT_LAST) begin
      s_d.hcnt = '0;
      s_d.line = next_line; // [R14]
      if (next_line == 10'h000) begin
        s_d.rscan = 5'h00;
        s_d.row_base = s_q.start; // [R6]
      end else if (s_q.rscan == s_q.char_height) begin // [R1]
        s_d.rscan = 5'h00;
        s_d.row_base = s_q.row_base + pitch_step; // [R15]
      end else begin
        s_d.rscan = s_q.rscan + 5'h01;
      end
      // Start is checked after end so a pulse that would end and restart stays high.
      if (s_q.vsync && next_line[3:0] == s_q.vs_finish[3:0]) begin // [R9]
        s_d.vsync = 1'b0;
      end
      if (next_line == vs_start) begin // [R8]
        s_d.vsync = 1'b1;
      end
    end else begin
      s_d.hcnt = s_q.hcnt + HCNT_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign host_rdata = s_q.rdata;
  assign fb_addr = s_q.addr;
  assign display_en = s_q.disp_en;
  assign vsync = s_q.vsync;
  assign cursor_on = s_q.cursor;
endmodule

// ==== vcr_crtc_sva.sv ====
// Port checker for the vertical timing and cursor controller.
`timescale 1ns/1ps
module vcr_crtc_chk import vcr_pkg::*; #(
  parameter int H_TOTAL = 100,
  parameter int H_ACTIVE = 80
) (
  input wire logic mclk, // Clock.
  input wire logic nrst, // Reset.
  input wire logic index_wr, // Index strobe.
  input wire logic data_rd, // Read strobe.
  input wire logic [7:0] host_wdata, // Write data.
  input wire logic [7:0] host_rdata, // Read data.
  input wire logic graphics_mode, // Graphics flag.
  input wire logic [15:0] fb_addr, // Fetch offset.
  input wire logic display_en, // Active flag.
  input wire logic vsync, // Sync.
  input wire logic cursor_on // Cursor.
);
  logic [7:0] idx_q;
  int ph_q;
  // Mirrors the character counter, which restarts from zero with every reset.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      idx_q <= 8'h00;
      ph_q <= 0;
    end else begin
      if (index_wr) idx_q <= host_wdata;
      ph_q <= (ph_q == H_TOTAL - 1) ? 0 : ph_q + 1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_rdata_hold; !$past(data_rd) |-> $stable(host_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_cursor_gfx; graphics_mode [*5] |-> !cursor_on; endproperty
  a_cursor_gfx: assert property (p_cursor_gfx) else $error("cursor in graphics");
  property p_cursor_act;
    cursor_on |-> display_en || $past(display_en) || $past(display_en, 2) || $past(display_en, 3);
  endproperty
  a_cursor_act: assert property (p_cursor_act) else $error("cursor outside area");
  property p_addr_step; display_en && $past(display_en) |-> fb_addr == $past(fb_addr) + 16'h1; endproperty
  a_addr_step: assert property (p_addr_step) else $error("fetch offset step");
  property p_rsvd; data_rd && idx_q == VCR_IDX_CURSOR_FIRST_LINE |=> host_rdata[7:6] == 2'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_vs_rise; $rose(vsync) |-> ph_q == 0; endproperty
  a_vs_rise: assert property (p_vs_rise) else $error("sync start off line edge");
  property p_vs_fall; $fell(vsync) |-> ph_q == 0; endproperty
  a_vs_fall: assert property (p_vs_fall) else $error("sync end off line edge");
  property p_de_win; display_en |-> ph_q >= 1 && ph_q <= H_ACTIVE; endproperty
  a_de_win: assert property (p_de_win) else $error("active flag outside columns");
  c_cursor: cover property (cursor_on);
  c_vs: cover property ($rose(vsync));
  c_gfx: cover property (graphics_mode && display_en);
endmodule
bind vcr_crtc vcr_crtc_chk #(.H_TOTAL(H_TOTAL), .H_ACTIVE(H_ACTIVE)) u_chk (
  .mclk(mclk), .nrst(nrst), .index_wr(index_wr), .data_rd(data_rd), .host_wdata(host_wdata),
  .host_rdata(host_rdata), .graphics_mode(graphics_mode), .fb_addr(fb_addr),
  .display_en(display_en), .vsync(vsync), .cursor_on(cursor_on));

// ==== vcr_monitor.sv ====
// Display monitor model that measures sync length and active cycles per frame.
`timescale 1ns/1ps
module vcr_monitor (
  input wire logic mclk, // Character clock.
  input wire logic vsync, // Sync from the controller.
  input wire logic display_en, // Active area flag.
  output int vs_len, // Cycles of the last finished sync pulse.
  output int de_frame // Active cycles between the last two sync starts.
);
  int vs_run = 0;
  int de_run = 0;
  logic vs_prev = 1'b0;
  // A monitor sees only the pins, so every count restarts at a sync start.
  always @(posedge mclk) begin
    vs_prev <= vsync;
    vs_run <= vsync ? vs_run + 1 : 0;
    de_run <= (vsync && !vs_prev) ? 0 : de_run + int'(display_en);
    if (vsync && !vs_prev) de_frame <= de_run;
    if (!vsync && vs_prev) vs_len <= vs_run;
  end
endmodule

// ==== vcr_crtc_tb.sv ====
// Self-checking testbench for the vertical timing and cursor controller.
`timescale 1ns/1ps
module vcr_crtc_tb;
  logic mclk = 1'b0, nrst = 1'b0, index_wr = 1'b0, data_wr = 1'b0, data_rd = 1'b0;
  logic graphics_mode = 1'b0, dword_pitch = 1'b0, display_en, vsync, cursor_on;
  logic [7:0] host_wdata = 8'h00, host_rdata;
  logic [15:0] fb_addr;
  int fails = 0, num_checks = 0, vs_len, de_frame;
  always #2.5 mclk = ~mclk;
  vcr_crtc #(.H_TOTAL(10), .H_ACTIVE(6), .V_TOTAL(10'h014)) dut (.mclk(mclk), .nrst(nrst),
    .index_wr(index_wr), .data_wr(data_wr), .data_rd(data_rd), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .graphics_mode(graphics_mode), .dword_pitch(dword_pitch),
    .fb_addr(fb_addr), .display_en(display_en), .vsync(vsync), .cursor_on(cursor_on));
  vcr_monitor mon (.mclk(mclk), .vsync(vsync), .display_en(display_en), .vs_len(vs_len),
    .de_frame(de_frame));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic [7:0] idx, input logic [7:0] val, input logic rd);
    index_wr <= 1'b1;
    host_wdata <= idx;
    @(posedge mclk);
    index_wr <= 1'b0;
    data_wr <= !rd;
    data_rd <= rd;
    host_wdata <= val;
    @(posedge mclk);
    data_wr <= 1'b0;
    data_rd <= 1'b0;
    @(posedge mclk);
    if (rd) check(16'(host_rdata), 16'(val));
  endtask
  task automatic wait_vs(input logic lvl);
    int n;
    for (n = 0; n < 250 && vsync !== lvl; n++) @(posedge mclk);
    if (n == 250) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic t_regs();
    logic [7:0] ix [11] = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h20};
    logic [7:0] rv [11] = '{8'h3F, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hBF, 8'hFF, 8'hFF, 8'h00};
    foreach (ix[i]) acc(ix[i], 8'h00, 1'b1);
    foreach (ix[i]) begin
      acc(ix[i], 8'hFF, 1'b0);
      acc(ix[i], rv[i], 1'b1);
    end
    $display("test registers done");
  endtask
  task automatic t_protect();
    acc(8'h11, 8'h80, 1'b0);
    acc(8'h07, 8'hFF, 1'b0);
    acc(8'h07, 8'h10, 1'b1);
    acc(8'h09, 8'h1F, 1'b0);
    acc(8'h09, 8'h1F, 1'b1);
    acc(8'h11, 8'h30, 1'b0);
    acc(8'h07, 8'hFF, 1'b0);
    acc(8'h07, 8'hFF, 1'b1);
    $display("test protection done");
  endtask
  // Mode bits are cursor off, graphics, doubleword pitch; the cursor sits on text row 3.
  task automatic frame(input logic [1:0] skew, input logic [2:0] mode, input logic [15:0] exp);
    logic [3:0][15:0] hist;
    int hits;
    hits = 0;
    acc(8'h0B, {1'b0, skew, 5'h02}, 1'b0);
    acc(8'h0A, {2'b00, mode[2], 5'h01}, 1'b0);
    graphics_mode <= mode[1];
    dword_pitch <= mode[0];
    wait_vs(1'b0);
    wait_vs(1'b1);
    for (int c = 0; c < 200; c++) begin
      @(posedge mclk);
      hist = {hist[2:0], fb_addr};
      if (cursor_on === 1'b1) begin
        hits++;
        check(hist[skew], 16'h0113);
      end
    end
    check(16'(hits), exp);
    check(16'(vs_len), 16'h0014);
    check(16'(de_frame), 16'h0060);
  endtask
  task automatic t_cursor();
    logic [15:0] cfg [12] = '{16'h0700, 16'h0903, 16'h0A01, 16'h0B02, 16'h0C01, 16'h0D00,
      16'h0E01, 16'h0F13, 16'h1011, 16'h1103, 16'h120F, 16'h1303};
    foreach (cfg[i]) acc(cfg[i][15:8], cfg[i][7:0], 1'b0);
    wait_vs(1'b1);
    for (int s = 0; s < 4; s++) frame(2'(s), 3'b000, 16'h0002);
    frame(2'h0, 3'b001, 16'h0000);
    frame(2'h0, 3'b010, 16'h0000);
    frame(2'h3, 3'b100, 16'h0000);
    $display("test cursor and timing done");
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_protect();
    t_cursor();
    give_verdict();
  end
endmodule
